// file: rxu_pkg.sv
/*
 * Shared constants for the receive urgent-request, oversize-count and
 * station-address block: register offsets, field positions, reset values
 * and limits.
 * Assumes both ends and the address filter are compiled after this file.
 */
package rxu_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int ADDR_W = 8;  // Device word-aligned byte offsets
    localparam int HADDR_W = 9;  // Software port adds host-own page
    localparam int DATA_W = 32;
    localparam int FREE_W = 14;  // Free FIFO space in bytes
    localparam int LEN_W = 14;  // Frame length in bytes
    localparam int DA_BITS = 48;

    // ****************************************************************
    // Device register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_DMA_STATE = 8'h08;
    localparam logic [7:0] OFS_URGENT = 8'h58;
    localparam logic [7:0] OFS_RSVD = 8'h5C;
    localparam logic [7:0] OFS_OVERSIZE = 8'h60;
    localparam logic [7:0] OFS_MAC_CTRL = 8'h64;
    localparam logic [7:0] OFS_STATS_BLOCK = 8'h68;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h6C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h70;
    localparam logic [7:0] OFS_STA_LO = 8'h78;
    localparam logic [7:0] OFS_STA_HI = 8'h7C;

    // Host-own registers on the software port
    localparam logic [8:0] HOFS_STATUS = 9'h100;
    localparam logic [8:0] HOFS_MASK = 9'h104;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MAC_STATS_ON_BIT = 0;
    localparam int BLOCK_OVERSIZE_BIT = 3;
    localparam int IRQ_W = 3;
    localparam int IRQ_STATS_BIT = 0;  // Statistics update
    localparam int IRQ_DESC_BIT = 1;  // Descriptor status written
    localparam int IRQ_MATCH_BIT = 2;  // Own-address frame seen
    localparam int HIRQ_W = 2;
    localparam int HIRQ_REFUSED_BIT = 0;  // Read refused outside polling
    localparam int HIRQ_DEV_BIT = 1;  // Device interrupt seen

    // ****************************************************************
    // Reset values and limits
    // ****************************************************************
    localparam logic [31:0] RST_DMA_STATE = 32'h0000_0000;
    localparam logic [15:0] RST_OVERSIZE = 16'h0000;
    localparam logic [7:0] RST_URGENT = 8'h04;
    localparam logic [47:0] RST_STATION = 48'h0000_0000_0000;
    localparam logic [7:0] URG_MIN = 8'h04;
    localparam logic [7:0] URG_MAX = 8'hFF;
    localparam int URG_UNIT_SHIFT = 5;  // 32 bytes per unit
    localparam logic [13:0] URG_MAX_BYTES = 14'h2000;  // 256 units
    localparam logic [13:0] LEN_PLAIN_MAX = 14'h5EE;  // 1518 bytes
    localparam logic [13:0] LEN_VLAN_MAX = 14'h5F2;  // 1522 bytes
    localparam logic [15:0] OVS_IRQ_LEVEL = 16'hC000;

endpackage

// file: rxu_if.sv
/*
 * Register link between the host controller and the device end.
 * Assumes one clock shared by both ends; the testbench ties them together.
 */
`timescale 1ns/100ps
interface rxu_if;

    // ****************************************************************
    // Link signals
    // ****************************************************************
    logic wr;  // One-cycle write strobe
    logic rd;  // One-cycle read strobe
    logic [7:0] addr;  // Word-aligned byte offset
    logic [31:0] wdata;
    logic [31:0] rdata;  // Valid the cycle after rd
    logic polling;  // Receive DMA sits in its polling state
    logic irq;  // Device interrupt level

    modport dev (
        input wr,
        input rd,
        input addr,
        input wdata,
        output rdata,
        output polling,
        output irq
    );

    modport host (
        output wr,
        output rd,
        output addr,
        output wdata,
        input rdata,
        input polling,
        input irq
    );

endinterface

// file: rxu_addr_match.sv
/*
 * Serial destination-address filter.
 * Assumes start pulses before the first address bit and bits arrive in
 * reception order, one per bit_valid, on the same clock.
 */
`timescale 1ns/100ps
module rxu_addr_match #(
    parameter int DA_BITS = 48
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [DA_BITS-1:0] station,
    input wire logic start,
    input wire logic bit_in,
    input wire logic bit_valid,
    output logic match,
    output logic match_valid
);

    // ****************************************************************
    // Compare state
    // ****************************************************************
    typedef enum logic [1:0] {
        RXU_IDLE = 2'b01,
        RXU_SHIFT = 2'b10
    } rxu_match_e;

    rxu_match_e state_r;  // Idle or collecting address bits
    logic [5:0] idx_r;  // Station bit under test
    logic miss_r;  // Any disagreement so far
    logic diff;  // Current bit disagrees
    logic last;  // Current bit is the final one

    assign diff = bit_in ^ station[idx_r];
    assign last = (idx_r == 6'(DA_BITS - 1));

    // Sequencer: a new start abandons any half-compared address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= RXU_IDLE;
            idx_r <= 6'h00;
            miss_r <= 1'b0;
        end else if (ce) begin
            if (start) begin
                state_r <= RXU_SHIFT;
                idx_r <= 6'h00;
                miss_r <= 1'b0;
            end else begin
                unique case (state_r)
                    RXU_IDLE: begin
                    end
                    RXU_SHIFT: begin
                        if (bit_valid) begin
                            miss_r <= miss_r | diff;
                            idx_r <= idx_r + 6'h01;
                            if (last) begin
                                state_r <= RXU_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Verdict: one pulse after the 48th bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            match <= 1'b0;
            match_valid <= 1'b0;
        end else if (ce) begin
            match_valid <= (state_r == RXU_SHIFT) && bit_valid && last && !start;
            if ((state_r == RXU_SHIFT) && bit_valid && last && !start) begin
                match <= !(miss_r | diff);
            end
        end
    end

endmodule

// file: rxu_host.sv
/*
 * Host controller end: takes software orders on a plain port and drives
 * the register link; keeps its own status and mask registers.
 * Assumes the device answers reads one cycle after the strobe.
 */
`timescale 1ns/100ps
module rxu_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [8:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic irq,
    rxu_if.host lnk
);

    // ****************************************************************
    // Writable-bit map of the device
    // ****************************************************************
    function automatic logic [31:0] wr_mask(input logic [7:0] a);
        unique case (a)
            rxu_pkg::OFS_URGENT: wr_mask = 32'h0000_00FF;
            rxu_pkg::OFS_OVERSIZE: wr_mask = 32'h0000_FFFF;
            rxu_pkg::OFS_MAC_CTRL: wr_mask = 32'h0000_0001;
            rxu_pkg::OFS_STATS_BLOCK: wr_mask = 32'h0000_0008;
            rxu_pkg::OFS_IRQ_STATUS: wr_mask = 32'h0000_0007;
            rxu_pkg::OFS_IRQ_MASK: wr_mask = 32'h0000_0007;
            rxu_pkg::OFS_STA_LO: wr_mask = 32'hFFFF_FFFF;
            rxu_pkg::OFS_STA_HI: wr_mask = 32'h0000_FFFF;
            default: wr_mask = 32'h0000_0000;
        endcase
    endfunction

    logic own;  // Address falls on the host page
    logic refuse;  // Read of the state word outside polling
    logic fwd_rd_r;  // Last read went to the device
    logic [31:0] own_rdata_r;
    logic [1:0] hstat_r;
    logic [1:0] hmask_r;
    logic [1:0] hevent;

    assign own = sw_addr[8];
    assign refuse = sw_rd && !own && (sw_addr[7:0] == rxu_pkg::OFS_DMA_STATE) && !lnk.polling;

    // Forwarding is combinational so the device answer lands one cycle later
    assign lnk.wr = sw_wr && !own;
    assign lnk.rd = sw_rd && !own && !refuse;
    assign lnk.addr = sw_addr[7:0];
    assign lnk.wdata = sw_wdata & wr_mask(sw_addr[7:0]);

    assign sw_rdata = fwd_rd_r ? lnk.rdata : own_rdata_r;
    assign hevent = {lnk.irq, refuse};
    assign irq = |(hstat_r & hmask_r);

    // Read steering and host-page read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fwd_rd_r <= 1'b0;
            own_rdata_r <= 32'h0000_0000;
        end else if (ce) begin
            fwd_rd_r <= sw_rd && !own && !refuse;
            if (sw_addr == rxu_pkg::HOFS_STATUS && sw_rd) begin
                own_rdata_r <= {30'h0000_0000, hstat_r};
            end else if (sw_addr == rxu_pkg::HOFS_MASK && sw_rd) begin
                own_rdata_r <= {30'h0000_0000, hmask_r};
            end else begin
                own_rdata_r <= 32'h0000_0000;  // Refused or unmapped read
            end
        end
    end

    // Sticky status: a new event beats a write-one clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hstat_r <= 2'b00;
        end else if (ce) begin
            hstat_r <= (hstat_r & ~((sw_wr && sw_addr == rxu_pkg::HOFS_STATUS) ? sw_wdata[1:0] : 2'b00)) | hevent;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hmask_r <= 2'b00;
        end else if (ce && sw_wr && sw_addr == rxu_pkg::HOFS_MASK) begin
            hmask_r <= sw_wdata[1:0];
        end
    end

endmodule

// file: rxu_device.sv
/*
 * Device end: receive DMA state word, urgent request from free FIFO space,
 * oversize-frame statistic and station-address filter, with registers
 * reached over the link.
 * Assumes the receive path and DMA engine share this clock; they pulse
 * frame_end, da_start, da_bit_valid, dma_state_load and dma_done.
 */
`timescale 1ns/100ps
module rxu_device (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    rxu_if.dev lnk,
    input wire logic [31:0] dma_state_in,
    input wire logic dma_state_load,
    input wire logic dma_polling,
    input wire logic dma_done,
    output logic desc_wr_valid,
    output logic [31:0] desc_status,
    input wire logic [13:0] fifo_free_bytes,
    output logic urgent_req,
    input wire logic frame_end,
    input wire logic frame_ok,
    input wire logic frame_vlan,
    input wire logic [13:0] frame_len,
    input wire logic da_start,
    input wire logic da_bit,
    input wire logic da_bit_valid,
    output logic addr_match,
    output logic addr_match_valid
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0] dma_state_r;  // Same layout as descriptor frame status
    logic [7:0] urgent_r;  // Urgent level in 32-byte units
    logic [15:0] ovs_r;  // Oversize-frame count
    logic [15:0] ovs_nxt;
    logic stats_on_r;  // Global statistics enable
    logic ovs_block_r;  // Oversize count blocked
    logic [47:0] station_r;  // Own station address
    logic [2:0] irq_stat_r;  // Sticky events
    logic [2:0] irq_mask_r;
    logic [2:0] irq_event;
    logic [31:0] rdata_r;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wr_urgent;
    logic wr_ovs;
    logic wr_irq_stat;
    assign wr_urgent = lnk.wr && hit(lnk.addr, rxu_pkg::OFS_URGENT);
    assign wr_ovs = lnk.wr && hit(lnk.addr, rxu_pkg::OFS_OVERSIZE);
    assign wr_irq_stat = lnk.wr && hit(lnk.addr, rxu_pkg::OFS_IRQ_STATUS);

    assign lnk.polling = dma_polling;
    assign lnk.irq = |(irq_stat_r & irq_mask_r);

    // ****************************************************************
    // Receive DMA state word
    // ****************************************************************
    // The DMA engine loads the full word; it is never host-writable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dma_state_r <= rxu_pkg::RST_DMA_STATE;
        end else if (ce && dma_state_load) begin
            dma_state_r <= dma_state_in;
        end
    end

    // Descriptor status write-back on DMA completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            desc_wr_valid <= 1'b0;
            desc_status <= 32'h0000_0000;
        end else if (ce) begin
            desc_wr_valid <= dma_done;
            if (dma_done) begin
                desc_status <= dma_state_r;
            end
        end
    end

    // ****************************************************************
    // Urgent request
    // ****************************************************************
    // Clamp in units, then scale; the top setting stands for 256 units,
    // not 255, so it is treated apart rather than scaled
    logic [7:0] urgent_eff;
    logic [13:0] urgent_bytes;
    assign urgent_eff = (urgent_r < rxu_pkg::URG_MIN) ? rxu_pkg::URG_MIN : urgent_r;
    assign urgent_bytes = (urgent_r == rxu_pkg::URG_MAX) ? rxu_pkg::URG_MAX_BYTES
        : 14'(urgent_eff) << rxu_pkg::URG_UNIT_SHIFT;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            urgent_r <= rxu_pkg::RST_URGENT;
        end else if (ce && wr_urgent) begin
            urgent_r <= lnk.wdata[7:0];
        end
    end

    // Registered compare keeps the request free of glitches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            urgent_req <= 1'b0;
        end else if (ce) begin
            urgent_req <= (fifo_free_bytes < urgent_bytes);
        end
    end

    // ****************************************************************
    // Oversize-frame statistic
    // ****************************************************************
    logic ovs_hit;
    assign ovs_hit = frame_end && frame_ok
        && (frame_len > (frame_vlan ? rxu_pkg::LEN_VLAN_MAX : rxu_pkg::LEN_PLAIN_MAX))
        && stats_on_r && !ovs_block_r;
    assign ovs_nxt = ovs_r + 16'h0001;

    // A host write in the same cycle as a frame takes precedence
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovs_r <= rxu_pkg::RST_OVERSIZE;
        end else if (ce) begin
            if (wr_ovs) begin
                ovs_r <= lnk.wdata[15:0];
            end else if (ovs_hit) begin
                ovs_r <= ovs_nxt;
            end
        end
    end

    // Statistics enable and block bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stats_on_r <= 1'b0;
            ovs_block_r <= 1'b0;
        end else if (ce && lnk.wr) begin
            if (hit(lnk.addr, rxu_pkg::OFS_MAC_CTRL)) begin
                stats_on_r <= lnk.wdata[rxu_pkg::MAC_STATS_ON_BIT];
            end
            if (hit(lnk.addr, rxu_pkg::OFS_STATS_BLOCK)) begin
                ovs_block_r <= lnk.wdata[rxu_pkg::BLOCK_OVERSIZE_BIT];
            end
        end
    end

    // ****************************************************************
    // Station address and filter
    // ****************************************************************
    // Octet order in the register is software's business; the filter
    // just walks bit 0 upward
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            station_r <= rxu_pkg::RST_STATION;
        end else if (ce && lnk.wr) begin
            if (hit(lnk.addr, rxu_pkg::OFS_STA_LO)) begin
                station_r[31:0] <= lnk.wdata;
            end
            if (hit(lnk.addr, rxu_pkg::OFS_STA_HI)) begin
                station_r[47:32] <= lnk.wdata[15:0];
            end
        end
    end

    // Receive-only filter; no transmit path touches the address
    rxu_addr_match #(
        .DA_BITS(rxu_pkg::DA_BITS)
    ) u_match (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .station(station_r),
        .start(da_start),
        .bit_in(da_bit),
        .bit_valid(da_bit_valid),
        .match(addr_match),
        .match_valid(addr_match_valid)
    );

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    always_comb begin
        irq_event = 3'b000;
        irq_event[rxu_pkg::IRQ_STATS_BIT] = ovs_hit && !wr_ovs && (ovs_nxt == rxu_pkg::OVS_IRQ_LEVEL);
        irq_event[rxu_pkg::IRQ_DESC_BIT] = dma_done;
        irq_event[rxu_pkg::IRQ_MATCH_BIT] = addr_match_valid && addr_match;
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= 3'b000;
        end else if (ce) begin
            irq_stat_r <= (irq_stat_r & ~(wr_irq_stat ? lnk.wdata[2:0] : 3'b000)) | irq_event;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_r <= 3'b000;
        end else if (ce && lnk.wr && hit(lnk.addr, rxu_pkg::OFS_IRQ_MASK)) begin
            irq_mask_r <= lnk.wdata[2:0];
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Reserved and unmapped offsets read as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (ce) begin
            rdata_r <= 32'h0000_0000;
            if (lnk.rd) begin
                unique case (lnk.addr)
                    rxu_pkg::OFS_DMA_STATE: rdata_r <= dma_state_r;
                    rxu_pkg::OFS_URGENT: rdata_r <= {24'h00_0000, urgent_r};
                    rxu_pkg::OFS_OVERSIZE: rdata_r <= {16'h0000, ovs_r};
                    rxu_pkg::OFS_MAC_CTRL: rdata_r <= {31'h0000_0000, stats_on_r};
                    rxu_pkg::OFS_STATS_BLOCK: rdata_r <= {28'h000_0000, ovs_block_r, 3'b000};
                    rxu_pkg::OFS_IRQ_STATUS: rdata_r <= {29'h0000_0000, irq_stat_r};
                    rxu_pkg::OFS_IRQ_MASK: rdata_r <= {29'h0000_0000, irq_mask_r};
                    rxu_pkg::OFS_STA_LO: rdata_r <= station_r[31:0];
                    rxu_pkg::OFS_STA_HI: rdata_r <= {16'h0000, station_r[47:32]};
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign lnk.rdata = rdata_r;

endmodule

// file: rxu_monitor.sv
/* Checker for the register link between host and device ends.
   Assumes one clock and takes the link signals as plain inputs. */
`timescale 1ns/100ps
module rxu_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic polling,
    input wire logic irq
);
    // ****************************************************************
    // Helper state and sequences
    // ****************************************************************
    logic [31:0] sta_seen_r;  // Last low station word sent down the link
    // Track the station write so the read-back has a reference
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sta_seen_r <= 32'h0;
        end else if (wr && addr == 8'h78) begin
            sta_seen_r <= wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Write then read of the low station word, one idle cycle between
    sequence s_sta_wr_rd;
        (wr && addr == 8'h78) ##2 (rd && addr == 8'h78);
    endsequence
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_poll_read; rd && addr == 8'h08 |-> polling; endproperty
    property p_rsvd_zero; rd && addr == 8'h5C |=> rdata == 32'h0; endproperty
    property p_urg_width; rd && addr == 8'h58 |=> rdata[31:8] == 24'h0; endproperty
    property p_ovs_width; rd && addr == 8'h60 |=> rdata[31:16] == 16'h0; endproperty
    property p_sta_hi_width; rd && addr == 8'h7C |=> rdata[31:16] == 16'h0; endproperty
    property p_sta_back; s_sta_wr_rd |=> rdata == sta_seen_r; endproperty
    property p_irq_width; rd && addr == 8'h6C |=> rdata[31:3] == 29'h0; endproperty
    property p_irq_masked; wr && addr == 8'h70 && wdata[2:0] == 3'h0 |=> !irq; endproperty
    a_poll_read: assert property (p_poll_read) else $error("state word read while not polling");
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved word not zero");
    a_urg_width: assert property (p_urg_width) else $error("urgent level wider than 8 bits");
    a_ovs_width: assert property (p_ovs_width) else $error("oversize count wider than 16 bits");
    a_sta_hi_width: assert property (p_sta_hi_width) else $error("station high word too wide");
    a_sta_back: assert property (p_sta_back) else $error("station low word read-back wrong");
    a_irq_width: assert property (p_irq_width) else $error("irq status has stray bits");
    a_irq_masked: assert property (p_irq_masked) else $error("irq high with all masked");
endmodule

// file: rx_urgent_dma_and_address_match_tb_top.sv
/* Testbench: host and device ends joined by the link, driven from the
   software port and the receive-side inputs. Assumes a 50 ns clock. */
`timescale 1ns/100ps
module rx_urgent_dma_and_address_match_tb_top;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clk = 1'b0, rst = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0, st_ld = 1'b0, poll = 1'b0, done = 1'b0;
    logic fe = 1'b0, fok = 1'b0, fvl = 1'b0, das = 1'b0, dab = 1'b0, dav = 1'b0, h_irq, dwv, urg, am, amv;
    logic [8:0] sw_addr = 9'h0;
    logic [31:0] sw_wdata = 32'h0, sw_rdata, st_in = 32'h0, dsts;
    logic [13:0] ffree = 14'h3FFF, flen = 14'h0;
    int n_fail = 0, n_tests = 0;
    rxu_if i_rxu_if();
    rxu_host i_rxu_host (.clk(clk), .rst(rst), .ce(1'b1), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(h_irq), .lnk(i_rxu_if));
    rxu_device i_rxu_device (.clk(clk), .rst(rst), .ce(1'b1), .lnk(i_rxu_if), .dma_state_in(st_in),
        .dma_state_load(st_ld), .dma_polling(poll), .dma_done(done), .desc_wr_valid(dwv),
        .desc_status(dsts), .fifo_free_bytes(ffree), .urgent_req(urg), .frame_end(fe), .frame_ok(fok),
        .frame_vlan(fvl), .frame_len(flen), .da_start(das), .da_bit(dab), .da_bit_valid(dav),
        .addr_match(am), .addr_match_valid(amv));
    rxu_monitor i_rxu_monitor (.clk(clk), .rst(rst), .wr(i_rxu_if.wr), .rd(i_rxu_if.rd),
        .addr(i_rxu_if.addr), .wdata(i_rxu_if.wdata), .rdata(i_rxu_if.rdata),
        .polling(i_rxu_if.polling), .irq(i_rxu_if.irq));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [8:0] a, logic [31:0] d);
        @(posedge clk) begin sw_addr <= a; sw_wdata <= d; sw_wr <= 1'b1; end
        @(posedge clk) sw_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so look there
    task automatic rd(logic [8:0] a, logic [31:0] e, string nm);
        @(posedge clk) begin sw_addr <= a; sw_rd <= 1'b1; end
        @(posedge clk) sw_rd <= 1'b0;
        #1 chk(nm, sw_rdata, e);
    endtask
    task automatic frame(logic [13:0] l, logic v, logic ok);
        @(posedge clk) begin fe <= 1'b1; flen <= l; fvl <= v; fok <= ok; end
        @(posedge clk) fe <= 1'b0;
    endtask
    // Address bits go out first-received first, bit 0 leading
    task automatic da_send(logic [47:0] v, logic exp);
        @(posedge clk) das <= 1'b1;
        for (int i = 0; i < 48; i++) begin
            @(posedge clk) begin das <= 1'b0; dab <= v[i]; dav <= 1'b1; end
        end
        @(posedge clk) dav <= 1'b0;
        #1 chk("match_valid", amv, 1'b1);
        chk("match", am, exp);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_and_state();
        rd(9'h060, 32'h0, "count_reset");
        rd(9'h058, 32'h4, "urgent_reset");
        rd(9'h05C, 32'h0, "reserved");
        rd(9'h008, 32'h0, "refused_read");
        rd(9'h100, 32'h1, "refused_flag");
        wr(9'h104, 32'h1);
        #1 chk("host_irq", h_irq, 1'b1);
        wr(9'h100, 32'h1);
        #1 chk("host_irq_off", h_irq, 1'b0);
        @(posedge clk) begin st_in <= 32'hA5C3_0F96; st_ld <= 1'b1; poll <= 1'b1; end
        @(posedge clk) st_ld <= 1'b0;
        rd(9'h008, 32'hA5C3_0F96, "state_word");
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        #1 chk("desc_valid", dwv, 1'b1);
        chk("desc_status", dsts, 32'hA5C3_0F96);
    endtask
    // Threshold edges for the floor, a plain value and the top setting
    task automatic t_urgent();
        logic [7:0] lv[4] = '{8'h00, 8'h04, 8'h10, 8'hFF};
        logic [13:0] thr;
        foreach (lv[k]) begin
            thr = (lv[k] == 8'hFF) ? 14'h2000 : ((lv[k] < 8'h04) ? 14'h80 : {lv[k], 5'h0});
            wr(9'h058, {24'h0, lv[k]});
            @(posedge clk) ffree <= thr - 14'h1;
            repeat (2) @(posedge clk);
            #1 chk("urgent_below", urg, 1'b1);
            @(posedge clk) ffree <= thr;
            repeat (2) @(posedge clk);
            #1 chk("urgent_at", urg, 1'b0);
        end
    endtask
    task automatic t_oversize();
        wr(9'h064, 32'h1);
        frame(14'h5EE, 1'b0, 1'b1);
        frame(14'h5EF, 1'b0, 1'b1);
        frame(14'h5F2, 1'b1, 1'b1);
        frame(14'h5F3, 1'b1, 1'b1);
        frame(14'h640, 1'b0, 1'b0);
        wr(9'h068, 32'h8);
        frame(14'h640, 1'b0, 1'b1);
        rd(9'h060, 32'h2, "oversize_count");
        wr(9'h068, 32'h0);
        wr(9'h060, 32'hBFFF);
        wr(9'h070, 32'h1);
        frame(14'h640, 1'b0, 1'b1);
        #1 chk("dev_irq", i_rxu_if.irq, 1'b1);
        // Descriptor bit is still sticky from the first scenario
        rd(9'h06C, 32'h3, "stats_irq");
        wr(9'h060, 32'hFFFF);
        frame(14'h640, 1'b0, 1'b1);
        rd(9'h060, 32'h0, "count_wrap");
        wr(9'h06C, 32'h7);
        wr(9'h070, 32'h0);
    endtask
    task automatic t_match();
        wr(9'h078, 32'h6745_2301);
        rd(9'h078, 32'h6745_2301, "station_lo");
        wr(9'h07C, 32'hAB89);
        rd(9'h07C, 32'hAB89, "station_hi");
        da_send(48'hAB89_6745_2301, 1'b1);
        da_send(48'h2B89_6745_2301, 1'b0);
        da_send(48'hAB89_6745_2300, 1'b0);
    endtask
    // ****************************************************************
    // Verdict, clock, watchdog and main sequence
    // ****************************************************************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset_and_state();
        t_urgent();
        t_oversize();
        t_match();
        give_verdict();
    end
endmodule
